// ===== rtl/mcu_exec_core.sv
// execution core for a subset of an 8-bit controller's instructions
// assumes instructions arrive already decoded, synchronous to ref_clk
`timescale 1ns/1ps
module mcu_exec_core import mcu_exec_pkg::*; (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // instruction issue
  input wire logic instr_valid,
  input wire instr_t instr,
  output logic instr_ready,
  // interrupt entry and wake-up
  input wire logic irq_entry,
  input wire logic wake,
  // data memory observation
  input wire logic [MEM_AW-1:0] mem_rd_addr,
  output logic [DATA_W-1:0] mem_rd_data,
  // architectural state
  output logic [PC_W-1:0] pc,
  output logic [DATA_W-1:0] acc,
  output status_t flags,
  output logic global_interrupt_enable,
  output logic sys_clk_en,
  output logic [WDT_W-1:0] wdt_count
);

  typedef struct packed {
    exec_state_t st;
    logic [PC_W-1:0] pc;
    logic [DATA_W-1:0] acc;
    status_t flags;
    logic gie;
    logic [SP_LAST:0][PC_W-1:0] stack;
    logic [SP_W-1:0] sp;
    logic [(1 << MEM_AW)-1:0][DATA_W-1:0] mem;
    logic [DATA_W-1:0] rd_data;
  } core_state_t;

  core_state_t s_reg;
  core_state_t s_next;
  logic [1:0] rst_pipe;
  logic rst_sync_n;
  logic taken;
  logic halt_go;
  logic first_go;
  logic second_go;
  logic wdt_pair_clear;
  logic wdt_expire;
  logic nib_carry;
  logic [DATA_W-1:0] mem_byte;
  alu_out_t alu;

  // stack pointer wraps over the six levels; overflow overwrites the oldest
  function automatic logic [SP_W-1:0] sp_step(input logic [SP_W-1:0] sp, input logic up);
    if (up) begin
      sp_step = (sp == SP_LAST) ? SP_RESET : sp + SP_ONE;
    end else begin
      sp_step = (sp == SP_RESET) ? SP_LAST : sp - SP_ONE;
    end
  endfunction

  // reset released through two flops so release is clean on ref_clk
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rst_pipe <= RST_PIPE_CLR;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end
  assign rst_sync_n = rst_pipe[1];

  // issue handshake; interrupt entry takes the slot when both arrive
  assign instr_ready = (s_reg.st == ST_RUN) && !irq_entry;
  assign taken = instr_valid && instr_ready;
  assign halt_go = taken && (instr.op == OP_HALT);
  assign first_go = taken && (instr.op == OP_WDT_FIRST);
  assign second_go = taken && (instr.op == OP_WDT_SECOND);
  assign mem_byte = s_reg.mem[instr.addr];

  mcu_alu u_alu (
    .op(instr.op),
    .acc(s_reg.acc),
    .mem_byte(mem_byte),
    .imm(instr.imm),
    .carry(s_reg.flags.carry),
    .half_carry(s_reg.flags.half_carry),
    .res(alu),
    .internal_nibble_carry(nib_carry)
  );

  wdt_unit u_wdt (
    .ref_clk(ref_clk),
    .rst_sync_n(rst_sync_n),
    .watchdog_preclear_first(first_go),
    .watchdog_preclear_second(second_go),
    .halt_clear(halt_go),
    .pair_clear(wdt_pair_clear),
    .expire(wdt_expire),
    .count(wdt_count)
  );

  // next-state of the whole core
  always_comb begin
    s_next = s_reg;
    s_next.rd_data = s_reg.mem[mem_rd_addr];
    case (s_reg.st)
      ST_RUN: begin
        if (irq_entry) begin
          s_next.stack[s_reg.sp] = s_reg.pc;
          s_next.sp = sp_step(s_reg.sp, 1'b1);
          s_next.pc = IRQ_VECTOR;
          s_next.gie = 1'b0;
        end else if (taken) begin
          s_next.pc = s_reg.pc + PC_ONE;
          if (alu.dest == DST_ACC) begin
            s_next.acc = alu.result;
          end
          if (alu.dest == DST_MEM) begin
            s_next.mem[instr.addr] = alu.result;
          end
          if (alu.z_upd) begin
            s_next.flags.zero = (alu.result == BYTE_ZERO);
          end
          if (alu.c_upd) begin
            s_next.flags.carry = alu.c_new;
          end
          case (instr.op)
            OP_HALT: begin
              s_next.st = ST_HALT;
              s_next.flags.powerdown_indicator = 1'b1;
              s_next.flags.watchdog_expiry_flag = 1'b0;
            end
            OP_JMP: s_next.pc = instr.target;
            OP_RET, OP_RET_IMM, OP_RET_INT: begin
              // second cycle is a dummy slot, as for a refetch
              s_next.sp = sp_step(s_reg.sp, 1'b0);
              s_next.pc = s_reg.stack[sp_step(s_reg.sp, 1'b0)];
              s_next.st = ST_RET2;
              if (instr.op == OP_RET_IMM) begin
                s_next.acc = instr.imm;
              end
              if (instr.op == OP_RET_INT) begin
                s_next.gie = 1'b1;
              end
            end
            default: ;
          endcase
        end
      end
      ST_RET2: s_next.st = ST_RUN;
      ST_HALT: begin
        // watchdog keeps running while halted, so its time-out also wakes
        if (wake || wdt_expire) begin
          s_next.st = ST_RUN;
        end
      end
      default: s_next.st = ST_RUN;
    endcase
    // completed pre-clear pair clears both flags
    if (wdt_pair_clear) begin
      s_next.flags.watchdog_expiry_flag = 1'b0;
      s_next.flags.powerdown_indicator = 1'b0;
    end
    // a time-out in the clearing cycle is not lost
    if (wdt_expire) begin
      s_next.flags.watchdog_expiry_flag = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // visible state straight from the state register
  assign pc = s_reg.pc;
  assign acc = s_reg.acc;
  assign flags = s_reg.flags;
  assign global_interrupt_enable = s_reg.gie;
  assign sys_clk_en = (s_reg.st != ST_HALT);
  assign mem_rd_data = s_reg.rd_data;

  // helper copies of the issued instruction and of the prior core state for the checks below
  logic taken_q;
  instr_t instr_q;
  logic [DATA_W-1:0] mem_byte_q;
  logic [DATA_W-1:0] acc_q;
  logic [PC_W-1:0] pc_q;
  status_t flags_q;
  logic expire_q;
  logic pair_q;
  logic [DATA_W-1:0] mem_at_q;

  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      taken_q <= 1'b0;
      instr_q <= '0;
      mem_byte_q <= BYTE_ZERO;
      acc_q <= BYTE_ZERO;
      pc_q <= PC_RESET;
      flags_q <= '0;
      expire_q <= 1'b0;
      pair_q <= 1'b0;
    end else begin
      taken_q <= taken;
      instr_q <= instr;
      mem_byte_q <= mem_byte;
      acc_q <= s_reg.acc;
      pc_q <= s_reg.pc;
      flags_q <= s_reg.flags;
      expire_q <= wdt_expire;
      pair_q <= wdt_pair_clear;
    end
  end
  assign mem_at_q = s_reg.mem[instr_q.addr];

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_sync_n);

  sequence ret_issue;
    taken && (instr.op == OP_RET);
  endsequence
  sequence ret_gap;
    !instr_ready ##1 (s_reg.st == ST_RUN);
  endsequence

  a_first_alone: assert property (
    taken_q && instr_q.op == OP_WDT_FIRST && !pair_q && !expire_q
    |-> flags == flags_q)
    else $error("lone first pre-clear changed flags");

  a_pair_clear: assert property (
    wdt_pair_clear && !wdt_expire
    |=> !flags.watchdog_expiry_flag && !flags.powerdown_indicator && wdt_count == WDT_ZERO)
    else $error("pre-clear pair did not clear watchdog state");

  a_invert_mem: assert property (
    taken_q && instr_q.op == OP_INV_MEM
    |-> mem_at_q == ~mem_byte_q && flags.carry == flags_q.carry)
    else $error("in-place invert wrong");

  a_invert_acc: assert property (
    taken_q && instr_q.op == OP_INV_ACC |-> acc == ~mem_byte_q && mem_at_q == mem_byte_q)
    else $error("invert to accumulator wrong");

  a_dec_mem: assert property (
    taken && instr.op == OP_DEC_MEM |=> mem_at_q == mem_byte_q - BYTE_ONE)
    else $error("decrement in place wrong");

  a_inc_acc: assert property (
    taken && instr.op == OP_INC_ACC |=> acc == mem_byte_q + BYTE_ONE)
    else $error("increment to accumulator wrong");

  a_jump_target: assert property (
    taken && instr.op == OP_JMP && !wdt_expire |=> pc == instr_q.target && flags == flags_q)
    else $error("jump did not load target");

  a_halt_entry: assert property (
    halt_go && !wdt_expire |=> !sys_clk_en && flags.powerdown_indicator
    && !flags.watchdog_expiry_flag
    && pc == pc_q + PC_ONE)
    else $error("power-down entry wrong");

  a_ret_two_cycle: assert property (
    ret_issue |=> ret_gap)
    else $error("return not two cycles");

  a_ret_int_gie: assert property (
    taken && instr.op == OP_RET_INT |=> global_interrupt_enable ##1 instr_ready || irq_entry)
    else $error("interrupt return did not enable interrupts");

  a_rotate_carry: assert property (
    taken_q && instr_q.op == OP_RL_CARRY
    |-> flags.carry == mem_byte_q[DATA_W-1] && mem_at_q == {mem_byte_q[DATA_W-2:0], flags_q.carry})
    else $error("rotate through carry wrong");

  a_zero_flag: assert property (
    taken && updates_zero(instr.op) |=> flags.zero == ($past(alu.result) == BYTE_ZERO))
    else $error("zero flag does not match result");

  // half-carry is never set here, so only the digit test drives the carry today
  a_daa_nibble: assert property (
    taken && instr.op == OP_DEC_ADJ
    |-> nib_carry == ((s_reg.acc[NIB_W-1:0] > BCD_MAX_DIGIT || s_reg.flags.half_carry)
    && !s_reg.flags.half_carry))
    else $error("nibble carry of decimal adjust wrong");

  a_daa_target: assert property (
    taken_q && instr_q.op == OP_DEC_ADJ && !expire_q
    |-> acc == acc_q && flags.zero == flags_q.zero
    && flags.powerdown_indicator == flags_q.powerdown_indicator
    && flags.watchdog_expiry_flag == flags_q.watchdog_expiry_flag)
    else $error("decimal adjust touched more than memory and carry");

  a_dec_acc: assert property (
    taken_q && instr_q.op == OP_DEC_ACC
    |-> acc == mem_byte_q - BYTE_ONE && mem_at_q == mem_byte_q)
    else $error("decrement to accumulator wrong");

  a_inc_mem: assert property (
    taken_q && instr_q.op == OP_INC_MEM |-> mem_at_q == mem_byte_q + BYTE_ONE)
    else $error("increment in place wrong");

  // a time-out may set the expiry flag in any cycle, so those cycles are left out
  a_rotate_mem: assert property (
    taken_q && instr_q.op == OP_RL_MEM && !expire_q
    |-> mem_at_q == {mem_byte_q[DATA_W-2:0], mem_byte_q[DATA_W-1]} && flags == flags_q)
    else $error("rotate in place wrong");

  a_rotate_acc: assert property (
    taken_q && instr_q.op == OP_RL_ACC && !expire_q
    |-> acc == {mem_byte_q[DATA_W-2:0], mem_byte_q[DATA_W-1]} && mem_at_q == mem_byte_q
    && flags == flags_q)
    else $error("rotate to accumulator wrong");

  a_move_flags: assert property (
    taken_q && !expire_q && (instr_q.op == OP_MOV_A_M || instr_q.op == OP_MOV_A_X ||
    instr_q.op == OP_MOV_M_A) |-> flags == flags_q)
    else $error("move changed a flag");

  a_nop_pc: assert property (
    taken_q && instr_q.op == OP_NOP && !expire_q
    |-> pc == pc_q + PC_ONE && acc == acc_q && flags == flags_q)
    else $error("no-operation changed state");

  a_ret_value: assert property (
    taken_q && instr_q.op == OP_RET_IMM |-> acc == instr_q.imm)
    else $error("return with value did not load accumulator");

  a_halt_wdt: assert property (
    halt_go |=> wdt_count == WDT_ZERO)
    else $error("power-down did not clear watchdog");

endmodule

// ===== rtl/mcu_exec_pkg.sv
// shared constants, opcodes and carrier types for the execution subset
// assumes one 200 MHz clock domain and an instruction source outside
package mcu_exec_pkg;

  localparam int DATA_W = 8;
  localparam int NIB_W = 4;
  localparam int MEM_AW = 6;
  localparam int PC_W = 11;
  localparam int SP_W = 3;
  localparam int WDT_W = 8;

  // nibble arithmetic of the decimal adjust, byte constants of increment, decrement and the zero test
  localparam logic [NIB_W-1:0] BCD_MAX_DIGIT = 4'h9;
  localparam logic [NIB_W-1:0] BCD_ADJUST = 4'h6;
  localparam logic [DATA_W-1:0] BYTE_ONE = 8'h01;
  localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;

  // program counter and six-level stack
  localparam logic [PC_W-1:0] PC_ONE = 11'h001;
  localparam logic [PC_W-1:0] PC_RESET = 11'h000;
  localparam logic [PC_W-1:0] IRQ_VECTOR = 11'h004;
  localparam logic [SP_W-1:0] SP_RESET = 3'h0;
  localparam logic [SP_W-1:0] SP_ONE = 3'h1;
  localparam logic [SP_W-1:0] SP_LAST = 3'h5;

  // watchdog divider and counter
  localparam logic [WDT_W-1:0] WDT_ZERO = 8'h00;
  localparam logic [WDT_W-1:0] WDT_ONE = 8'h01;
  localparam logic [WDT_W-1:0] WDT_MAX = 8'hFF;
  localparam logic [WDT_W-1:0] PRESCALE_MAX = 8'hFF;

  // reset release pipeline
  localparam logic [1:0] RST_PIPE_CLR = 2'h0;

  typedef enum logic [4:0] {
    OP_NOP, OP_WDT_FIRST, OP_WDT_SECOND, OP_INV_MEM, OP_INV_ACC, OP_DEC_ADJ,
    OP_DEC_MEM, OP_DEC_ACC, OP_HALT, OP_INC_MEM, OP_INC_ACC, OP_JMP,
    OP_MOV_A_M, OP_MOV_A_X, OP_MOV_M_A, OP_OR_A_M, OP_OR_A_X, OP_OR_M,
    OP_RET, OP_RET_IMM, OP_RET_INT, OP_RL_MEM, OP_RL_ACC, OP_RL_CARRY
  } op_t;

  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_RET2 = 2'b01,
    ST_HALT = 2'b11
  } exec_state_t;

  typedef enum logic [1:0] {DST_NONE, DST_ACC, DST_MEM} dest_t;

  typedef struct packed {
    op_t op;
    logic [MEM_AW-1:0] addr;
    logic [DATA_W-1:0] imm;
    logic [PC_W-1:0] target;
  } instr_t;

  typedef struct packed {
    logic watchdog_expiry_flag;
    logic powerdown_indicator;
    logic overflow;
    logic zero;
    logic half_carry;
    logic carry;
  } status_t;

  typedef struct packed {
    logic [DATA_W-1:0] result;
    dest_t dest;
    logic z_upd;
    logic c_upd;
    logic c_new;
  } alu_out_t;

  // ops whose result drives the zero flag
  function automatic logic updates_zero(input op_t op);
    case (op)
      OP_INV_MEM, OP_INV_ACC, OP_DEC_MEM, OP_DEC_ACC, OP_INC_MEM, OP_INC_ACC,
      OP_OR_A_M, OP_OR_A_X, OP_OR_M: updates_zero = 1'b1;
      default: updates_zero = 1'b0;
    endcase
  endfunction

endpackage

// ===== rtl/mcu_alu.sv
// data path of the subset: result, destination and flag updates
// assumes operands are stable for the whole cycle; purely combinational
`timescale 1ns/1ps
module mcu_alu import mcu_exec_pkg::*; (
  // operation and operands
  input wire op_t op,
  input wire logic [DATA_W-1:0] acc,
  input wire logic [DATA_W-1:0] mem_byte,
  input wire logic [DATA_W-1:0] imm,
  input wire logic carry,
  input wire logic half_carry,
  // result
  output alu_out_t res,
  output logic internal_nibble_carry
);

  logic lo_adj;
  logic hi_adj;
  logic [NIB_W-1:0] lo_nib;
  logic [NIB_W-1:0] hi_nib;
  logic [NIB_W:0] hi_sum;

  // decimal adjust works on the accumulator, result goes to memory
  always_comb begin
    lo_adj = (acc[NIB_W-1:0] > BCD_MAX_DIGIT) || half_carry;
    internal_nibble_carry = lo_adj ? ~half_carry : 1'b0;
    lo_nib = lo_adj ? acc[NIB_W-1:0] + BCD_ADJUST : acc[NIB_W-1:0];
    hi_sum = {1'b0, acc[DATA_W-1:NIB_W]} + {{NIB_W{1'b0}}, internal_nibble_carry};
    hi_adj = (hi_sum > {1'b0, BCD_MAX_DIGIT}) || carry;
    // carry out of the high nibble is dropped, only the flag records it
    hi_nib = hi_adj ? hi_sum[NIB_W-1:0] + BCD_ADJUST : hi_sum[NIB_W-1:0];
  end

  // per-op result and destination
  always_comb begin
    res.result = acc;
    res.dest = DST_NONE;
    res.z_upd = updates_zero(op);
    res.c_upd = 1'b0;
    res.c_new = carry;
    case (op)
      OP_INV_MEM: begin
        res.result = ~mem_byte;
        res.dest = DST_MEM;
      end
      OP_INV_ACC: begin
        res.result = ~mem_byte;
        res.dest = DST_ACC;
      end
      OP_DEC_ADJ: begin
        res.result = {hi_nib, lo_nib};
        res.dest = DST_MEM;
        res.c_upd = hi_adj;
        res.c_new = 1'b1;
      end
      OP_DEC_MEM: begin
        res.result = mem_byte - BYTE_ONE;
        res.dest = DST_MEM;
      end
      OP_DEC_ACC: begin
        res.result = mem_byte - BYTE_ONE;
        res.dest = DST_ACC;
      end
      OP_INC_MEM: begin
        res.result = mem_byte + BYTE_ONE;
        res.dest = DST_MEM;
      end
      OP_INC_ACC: begin
        res.result = mem_byte + BYTE_ONE;
        res.dest = DST_ACC;
      end
      OP_MOV_A_M: begin
        res.result = mem_byte;
        res.dest = DST_ACC;
      end
      OP_MOV_A_X: begin
        res.result = imm;
        res.dest = DST_ACC;
      end
      OP_MOV_M_A: begin
        res.result = acc;
        res.dest = DST_MEM;
      end
      OP_OR_A_M: begin
        res.result = acc | mem_byte;
        res.dest = DST_ACC;
      end
      OP_OR_A_X: begin
        res.result = acc | imm;
        res.dest = DST_ACC;
      end
      OP_OR_M: begin
        res.result = acc | mem_byte;
        res.dest = DST_MEM;
      end
      OP_RL_MEM: begin
        res.result = {mem_byte[DATA_W-2:0], mem_byte[DATA_W-1]};
        res.dest = DST_MEM;
      end
      OP_RL_ACC: begin
        res.result = {mem_byte[DATA_W-2:0], mem_byte[DATA_W-1]};
        res.dest = DST_ACC;
      end
      OP_RL_CARRY: begin
        res.result = {mem_byte[DATA_W-2:0], carry};
        res.dest = DST_MEM;
        res.c_upd = 1'b1;
        res.c_new = mem_byte[DATA_W-1];
      end
      default: ;
    endcase
  end

endmodule

// ===== rtl/wdt_unit.sv
// watchdog prescaler and counter with the paired pre-clear tracking
// assumes one-cycle strobes from the core, in its reset domain
`timescale 1ns/1ps
module wdt_unit import mcu_exec_pkg::*; (
  // clock and synchronised reset
  input wire logic ref_clk,
  input wire logic rst_sync_n,
  // strobes from the core
  input wire logic watchdog_preclear_first,
  input wire logic watchdog_preclear_second,
  input wire logic halt_clear,
  // results
  output logic pair_clear,
  output logic expire,
  output logic [WDT_W-1:0] count
);

  typedef struct packed {
    logic [WDT_W-1:0] prescale;
    logic [WDT_W-1:0] count;
    logic first_seen;
    logic second_seen;
    logic expire;
  } wdt_state_t;

  wdt_state_t s_reg;
  wdt_state_t s_next;
  logic tick;

  // the clear only completes once both halves were seen, in either order
  assign pair_clear = (watchdog_preclear_first && s_reg.second_seen) ||
                      (watchdog_preclear_second && s_reg.first_seen);
  assign expire = s_reg.expire;
  assign count = s_reg.count;

  // prescaler is the enable divider for the counter
  always_comb begin
    s_next = s_reg;
    tick = (s_reg.prescale == PRESCALE_MAX);
    s_next.prescale = s_reg.prescale + WDT_ONE;
    s_next.expire = tick && (s_reg.count == WDT_MAX);
    if (tick) begin
      s_next.count = s_reg.count + WDT_ONE;
    end
    if (watchdog_preclear_first) begin
      s_next.first_seen = 1'b1;
    end
    if (watchdog_preclear_second) begin
      s_next.second_seen = 1'b1;
    end
    if (pair_clear) begin
      s_next.first_seen = 1'b0;
      s_next.second_seen = 1'b0;
    end
    if (pair_clear || halt_clear) begin
      s_next.prescale = WDT_ZERO;
      s_next.count = WDT_ZERO;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

endmodule

// ===== bench/test_mcu_instruction_semantics_subset.sv
// self-checking bench for the execution core of the instruction subset
// assumes the core's ready/valid issue port and a 200 MHz ref_clk
`timescale 1ns/1ps
module test_mcu_instruction_semantics_subset import mcu_exec_pkg::*;;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic instr_valid = 1'b0;
  instr_t instr = '0;
  logic irq_entry = 1'b0;
  logic wake = 1'b0;
  logic [MEM_AW-1:0] mem_rd_addr = '0;
  logic instr_ready;
  logic [DATA_W-1:0] mem_rd_data;
  logic [PC_W-1:0] pc;
  logic [DATA_W-1:0] acc;
  status_t flags;
  logic global_interrupt_enable;
  logic sys_clk_en;
  logic [WDT_W-1:0] wdt_count;
  int miscompares = 0;
  int checked = 0;
  // bench copy of the flags that these tests can move
  logic ez = 1'b0;
  logic ec = 1'b0;
  logic epd = 1'b0;
  logic [DATA_W-1:0] v;
  logic [PC_W-1:0] pc_keep;

  always #2.5 ref_clk = ~ref_clk;

  mcu_exec_core i_dut (
    .ref_clk(ref_clk), .rstn(rstn), .instr_valid(instr_valid), .instr(instr),
    .instr_ready(instr_ready), .irq_entry(irq_entry), .wake(wake),
    .mem_rd_addr(mem_rd_addr), .mem_rd_data(mem_rd_data), .pc(pc), .acc(acc),
    .flags(flags), .global_interrupt_enable(global_interrupt_enable),
    .sys_clk_en(sys_clk_en), .wdt_count(wdt_count)
  );

  function automatic status_t ef();
    ef = status_t'({1'b0, epd, 1'b0, ez, 1'b0, ec});
  endfunction

  task automatic cmp_v(input string n, input logic [PC_W-1:0] e, input logic [PC_W-1:0] g);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic cmp_f(input string n);
    checked++;
    if (flags !== ef()) begin
      miscompares++;
      $display("CHECK FAILED %s expected %b seen %b", n, ef(), flags);
    end
  endtask

  // tasks start and end 1 ns after a rising edge; ready is settled then
  task automatic issue(input op_t o, input logic [MEM_AW-1:0] a = '0,
                       input logic [DATA_W-1:0] x = '0, input logic [PC_W-1:0] t = '0);
    int n;
    // one idle edge first, so valid never drops and rises in one time step
    @(posedge ref_clk);
    #1;
    instr_valid = 1'b1;
    instr = '{op: o, addr: a, imm: x, target: t};
    n = 0;
    while (instr_ready !== 1'b1 && n < 20) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    if (n == 20) cmp_v("ready wait", 11'h001, 11'h000);
    @(posedge ref_clk);
    #1;
    instr_valid = 1'b0;
  endtask

  task automatic rd(input logic [MEM_AW-1:0] a);
    mem_rd_addr = a;
    @(posedge ref_clk);
    #1;
    v = mem_rd_data;
  endtask

  task automatic set_mem(input logic [MEM_AW-1:0] a, input logic [DATA_W-1:0] x);
    issue(OP_MOV_A_X, '0, x);
    issue(OP_MOV_M_A, a);
  endtask

  // one-cycle pulse on wake or on irq_entry
  task automatic strobe(input bit w);
    // idle edge lets the dead cycle after a return pass, so the pulse lands in RUN
    @(posedge ref_clk);
    #1;
    if (w) wake = 1'b1;
    else irq_entry = 1'b1;
    @(posedge ref_clk);
    #1;
    wake = 1'b0;
    irq_entry = 1'b0;
  endtask

  task automatic t_incdec();
    set_mem(6'h01, 8'hFF);
    cmp_f("move flags");
    issue(OP_INC_MEM, 6'h01);
    ez = 1'b1;
    rd(6'h01);
    cmp_v("inc mem", 11'h000, PC_W'(v));
    cmp_f("inc flags");
    issue(OP_INC_ACC, 6'h01);
    ez = 1'b0;
    cmp_v("inc acc", 11'h001, PC_W'(acc));
    cmp_f("inca flags");
    issue(OP_DEC_MEM, 6'h01);
    rd(6'h01);
    cmp_v("dec mem", 11'h0FF, PC_W'(v));
    issue(OP_DEC_ACC, 6'h01);
    rd(6'h01);
    cmp_v("dec acc", 11'h0FE, PC_W'(acc));
    cmp_v("deca mem", 11'h0FF, PC_W'(v));
    cmp_f("dec flags");
    $display("test incdec done");
  endtask

  task automatic t_invor();
    set_mem(6'h02, 8'hA5);
    issue(OP_INV_ACC, 6'h02);
    rd(6'h02);
    cmp_v("inv acc", 11'h05A, PC_W'(acc));
    cmp_v("inva mem", 11'h0A5, PC_W'(v));
    issue(OP_INV_MEM, 6'h02);
    rd(6'h02);
    cmp_v("inv mem", 11'h05A, PC_W'(v));
    cmp_f("inv flags");
    issue(OP_MOV_A_X, '0, 8'h00);
    issue(OP_OR_A_M, 6'h02);
    cmp_v("or acc mem", 11'h05A, PC_W'(acc));
    issue(OP_MOV_A_X, '0, 8'h00);
    issue(OP_OR_A_X, '0, 8'h00);
    ez = 1'b1;
    cmp_f("or zero");
    issue(OP_OR_M, 6'h02);
    ez = 1'b0;
    rd(6'h02);
    cmp_v("or mem", 11'h05A, PC_W'(v));
    cmp_f("orm flags");
    issue(OP_MOV_A_M, 6'h02);
    cmp_v("mov acc", 11'h05A, PC_W'(acc));
    $display("test invor done");
  endtask

  task automatic t_rotate();
    set_mem(6'h04, 8'h81);
    issue(OP_RL_ACC, 6'h04);
    rd(6'h04);
    cmp_v("rla acc", 11'h003, PC_W'(acc));
    cmp_v("rla mem", 11'h081, PC_W'(v));
    issue(OP_RL_MEM, 6'h04);
    rd(6'h04);
    cmp_v("rl mem", 11'h003, PC_W'(v));
    cmp_f("rl flags");
    set_mem(6'h04, 8'h81);
    issue(OP_RL_CARRY, 6'h04);
    ec = 1'b1;
    rd(6'h04);
    cmp_v("rlc mem", 11'h002, PC_W'(v));
    cmp_f("rlc carry out");
    issue(OP_RL_CARRY, 6'h04);
    ec = 1'b0;
    rd(6'h04);
    cmp_v("rlc carry in", 11'h005, PC_W'(v));
    cmp_f("rlc carry clr");
    $display("test rotate done");
  endtask

  // operands chosen to hit each nibble branch, carry entering and leaving
  task automatic t_daa();
    logic [DATA_W-1:0] din [4] = '{8'h15, 8'h1A, 8'h9A, 8'h12};
    logic [DATA_W-1:0] dout [4] = '{8'h15, 8'h20, 8'h00, 8'h72};
    logic dc [4] = '{1'b0, 1'b0, 1'b1, 1'b1};
    for (int i = 0; i < 4; i++) begin
      issue(OP_MOV_A_X, '0, din[i]);
      issue(OP_DEC_ADJ, 6'h03);
      ec = dc[i];
      rd(6'h03);
      cmp_v("daa mem", PC_W'(dout[i]), PC_W'(v));
      cmp_v("daa acc", PC_W'(din[i]), PC_W'(acc));
      cmp_f("daa flags");
    end
    $display("test daa done");
  endtask

  task automatic t_flow();
    issue(OP_JMP, '0, '0, 11'h7F0);
    cmp_v("jmp pc", 11'h7F0, pc);
    issue(OP_NOP);
    cmp_v("nop pc", 11'h7F1, pc);
    cmp_f("nop flags");
    strobe(1'b0);
    cmp_v("irq pc", IRQ_VECTOR, pc);
    issue(OP_RET_INT);
    cmp_v("interrupt_return_op pc", 11'h7F1, pc);
    cmp_v("interrupt_return_op gie", 11'h001, PC_W'(global_interrupt_enable));
    strobe(1'b0);
    issue(OP_RET_IMM, '0, 8'h3C);
    cmp_v("retv pc", 11'h7F1, pc);
    cmp_v("retv acc", 11'h03C, PC_W'(acc));
    strobe(1'b0);
    issue(OP_RET);
    cmp_v("ret pc", 11'h7F1, pc);
    cmp_v("ret busy", 11'h000, PC_W'(instr_ready));
    cmp_f("ret flags");
    $display("test flow done");
  endtask

  task automatic t_halt();
    // let the watchdog count past zero so the clear is visible
    repeat (300) @(posedge ref_clk);
    #1;
    pc_keep = pc;
    issue(OP_HALT);
    epd = 1'b1;
    cmp_v("halt pc", pc_keep + PC_ONE, pc);
    cmp_v("halt clk", 11'h000, PC_W'(sys_clk_en));
    cmp_v("halt wdt", 11'h000, PC_W'(wdt_count));
    cmp_f("halt flags");
    strobe(1'b1);
    cmp_v("wake clk", 11'h001, PC_W'(sys_clk_en));
    rd(6'h01);
    cmp_v("halt keeps mem", 11'h0FF, PC_W'(v));
    issue(OP_WDT_SECOND);
    cmp_f("second alone");
    issue(OP_NOP);
    repeat (300) @(posedge ref_clk);
    #1;
    issue(OP_WDT_FIRST);
    epd = 1'b0;
    cmp_f("pair clear");
    cmp_v("pair wdt", 11'h000, PC_W'(wdt_count));
    issue(OP_HALT);
    epd = 1'b1;
    strobe(1'b1);
    issue(OP_WDT_FIRST);
    cmp_f("first alone");
    issue(OP_WDT_SECOND);
    epd = 1'b0;
    cmp_f("pair second");
    $display("test halt done");
  endtask

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // whole sequence needs well under 2000 cycles
  initial begin
    #(5 * 20000);
    miscompares++;
    close_out();
  end

  initial begin
    repeat (2) @(posedge ref_clk);
    #1;
    rstn = 1'b1;
    repeat (3) @(posedge ref_clk);
    #1;
    t_incdec();
    t_invor();
    t_rotate();
    t_daa();
    t_flow();
    t_halt();
    close_out();
  end
endmodule
